// File: plst_phy_end.sv
// Purpose: phy end of the phy-link port: status, grant/transmit, receive
// Assumes: arbitration, request decoding and line coding sit outside
// Notes: control pair outputs decode the state register directly
`timescale 1ns/1ns
module plst_phy_end #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  plst_link_if.phy lnk,
  input wire logic arbGapSeen,
  input wire logic subGapSeen,
  input wire logic busResetSeen,
  input wire logic regReadReq,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regData,
  output logic busRequest,
  input wire logic arbWon,
  input wire logic rxStart,
  input wire logic rxValid,
  input wire logic [1:0] rxDibit,
  input wire logic rxEnd,
  output logic txValid,
  output logic [1:0] txDibit,
  output logic busDataOn,
  output logic busTotem,
  output logic arbTick
);
  // the status stream layout leaves room for nothing else
  if (ADDR_W != 4 || DATA_W != 8) begin
    $error("status stream holds a 4-bit address and 8-bit data");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_STAT, S_STAT_GAP, S_GRANT, S_GRANT_IDLE, S_TURN,
    S_LINK_OWN, S_END_IDLE, S_REGRANT, S_RX_PRE, S_RX_SPD, S_RX_DATA
  } plst_phy_state_t;

  plst_phy_state_t state_reg;
  plst_phy_state_t state_next;
  logic [1:0] ctlQ_reg;
  logic [1:0] dataQ_reg;
  logic [1:0] prevQ_reg;
  logic sawTx_reg;
  logic moreWanted_reg;
  logic [2:0] flags_reg;
  logic readPend_reg;
  logic [ADDR_W-1:0] rdAddr_reg;
  logic [DATA_W-1:0] rdData_reg;
  logic [15:0] statWord_reg;
  logic statFull_reg;
  logic [2:0] statIdx_reg;
  logic [3:0] regrantCnt_reg;
  logic grantPend_reg;
  logic [1:0] rxData_reg;
  logic [17:0] arbAcc_reg;
  logic [17:0] arbSum;
  logic statPending;
  logic statDone;
  logic secondIdle;

  assign statPending = (|flags_reg) | readPend_reg;
  assign statDone = (state_reg == S_STAT) &&
    (statIdx_reg == (statFull_reg ? plst_pkg::STAT_FULL_LAST : plst_pkg::STAT_SHORT_LAST));
  // release code: idle that follows an idle or a hold, never the one right after transmit
  assign secondIdle = (ctlQ_reg == plst_pkg::LNK_IDLE) && (prevQ_reg != plst_pkg::LNK_TRANSMIT);

  // arbitration clock enable, fractional so the mean rate is exact
  assign arbSum = arbAcc_reg + 18'(plst_pkg::ARB_CLK_KHZ);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arbAcc_reg <= 18'h0;
      arbTick <= 1'b0;
    end else if (arbSum >= 18'(plst_pkg::CLK_KHZ)) begin
      arbAcc_reg <= arbSum - 18'(plst_pkg::CLK_KHZ);
      arbTick <= 1'b1;
    end else begin
      arbAcc_reg <= arbSum;
      arbTick <= 1'b0;
    end
  end

  // registered copies of the lines; decisions never use the raw wire
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctlQ_reg <= 2'h0;
      dataQ_reg <= 2'h0;
      busRequest <= 1'b0;
    end else begin
      ctlQ_reg <= lnk.ctlWire;
      dataQ_reg <= lnk.dataWire;
      busRequest <= lnk.reqLine;
    end
  end

  // state sequencing; receive beats grant beats status
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (rxStart) begin
          state_next = S_RX_PRE;
        end else if (grantPend_reg) begin
          state_next = S_GRANT;
        end else if (statPending) begin
          state_next = S_STAT;
        end
      end
      S_STAT: begin
        if (rxStart) begin
          state_next = S_RX_PRE;
        end else if (statDone) begin
          state_next = S_STAT_GAP;
        end
      end
      S_STAT_GAP: state_next = rxStart ? S_RX_PRE : S_IDLE;
      S_GRANT: state_next = S_GRANT_IDLE;
      S_GRANT_IDLE: state_next = S_TURN;
      S_TURN: state_next = S_LINK_OWN;
      S_LINK_OWN: begin
        if (secondIdle) begin
          state_next = S_END_IDLE;
        end
      end
      S_END_IDLE: state_next = moreWanted_reg ? S_REGRANT : S_IDLE;
      S_REGRANT: begin
        if (arbTick && regrantCnt_reg == plst_pkg::REGRANT_ARB_CLKS - 4'h1) begin
          state_next = S_GRANT;
        end
      end
      S_RX_PRE: state_next = S_RX_SPD;
      S_RX_SPD: state_next = S_RX_DATA;
      S_RX_DATA: state_next = rxEnd ? S_IDLE : S_RX_DATA;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // pending grant from arbitration; a receive means the request was lost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      grantPend_reg <= 1'b0;
    end else if (state_next == S_RX_PRE || state_reg == S_GRANT) begin
      grantPend_reg <= 1'b0;
    end else if (arbWon && busRequest) begin
      grantPend_reg <= 1'b1;
    end
  end

  // sticky status sources; a new event in the clearing cycle survives
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 3'h0;
      readPend_reg <= 1'b0;
      rdAddr_reg <= '0;
      rdData_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~(statDone ? statWord_reg[2:0] : 3'h0)) |
        {busResetSeen, subGapSeen, arbGapSeen};
      if (regReadReq) begin
        readPend_reg <= 1'b1;
        rdAddr_reg <= regAddr;
        rdData_reg <= regData;
      end else if (statDone && statFull_reg) begin
        readPend_reg <= 1'b0;
      end
    end
  end

  // snapshot at start; an interrupted transfer restarts from bit 0 later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      statWord_reg <= 16'h0;
      statFull_reg <= 1'b0;
      statIdx_reg <= 3'h0;
    end else if (state_reg != S_STAT && state_next == S_STAT) begin
      statWord_reg <= {rdData_reg, rdAddr_reg, 1'b0, flags_reg};
      statFull_reg <= readPend_reg;
      statIdx_reg <= 3'h0;
    end else if (state_reg == S_STAT) begin
      statIdx_reg <= statIdx_reg + 3'h1;
    end
  end

  // link ownership watch: hold, packet bits and the release pattern
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prevQ_reg <= 2'h0;
      sawTx_reg <= 1'b0;
      moreWanted_reg <= 1'b0;
      txValid <= 1'b0;
      txDibit <= 2'h0;
      busDataOn <= 1'b0;
      busTotem <= 1'b0;
    end else begin
      txValid <= 1'b0;
      busDataOn <= 1'b0;
      busTotem <= 1'b0;
      if (state_reg == S_TURN) begin
        // keeps the first code seen from counting as a second idle
        prevQ_reg <= plst_pkg::LNK_TRANSMIT;
        sawTx_reg <= 1'b0;
        moreWanted_reg <= 1'b0;
      end else if (state_reg == S_LINK_OWN) begin
        prevQ_reg <= ctlQ_reg;
        if (ctlQ_reg == plst_pkg::LNK_TRANSMIT) begin
          sawTx_reg <= 1'b1;
          txValid <= 1'b1;
          txDibit <= dataQ_reg;
          busTotem <= 1'b1;
        end else if (ctlQ_reg == plst_pkg::LNK_HOLD) begin
          if (sawTx_reg) begin
            moreWanted_reg <= 1'b1;
          end else begin
            busDataOn <= 1'b1;
          end
        end
      end
    end
  end

  // packet dibits shown one cycle after they are offered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regrantCnt_reg <= 4'h0;
      rxData_reg <= 2'h0;
    end else begin
      if (state_reg != S_REGRANT) begin
        regrantCnt_reg <= 4'h0;
      end else if (arbTick) begin
        regrantCnt_reg <= regrantCnt_reg + 4'h1;
      end
      if (rxValid) begin
        rxData_reg <= rxDibit;
      end
    end
  end

  // control pair and data lines from the state register
  always_comb begin
    lnk.phyOe_n = 1'b0;
    lnk.phyCtl = plst_pkg::PHY_IDLE;
    lnk.phyData = 2'h0;
    case (state_reg)
      S_STAT: begin
        lnk.phyCtl = plst_pkg::PHY_STATUS;
        lnk.phyData = statWord_reg[{statIdx_reg, 1'b0} +: 2];
      end
      S_GRANT: lnk.phyCtl = plst_pkg::PHY_TRANSMIT;
      S_TURN, S_LINK_OWN: lnk.phyOe_n = 1'b1;
      S_RX_PRE: begin
        lnk.phyCtl = plst_pkg::PHY_RECEIVE;
        lnk.phyData = plst_pkg::DIBIT_HIGH;
      end
      S_RX_SPD: begin
        lnk.phyCtl = plst_pkg::PHY_RECEIVE;
        lnk.phyData = plst_pkg::SPEED_CODE;
      end
      S_RX_DATA: begin
        lnk.phyCtl = plst_pkg::PHY_RECEIVE;
        lnk.phyData = rxData_reg;
      end
      default: lnk.phyCtl = plst_pkg::PHY_IDLE;
    endcase
  end
endmodule

// File: plst_pkg.sv
// What this block does
// - status waits for idle interface
// - status code with first two bits
// - status code held, packet may suspend
// - two idle cycles between status transfers
// - normally only four flag bits sent
// - full sixteen bits after register read
// - bit0 arb reset gap, bit1 subaction gap
// - bit2 bus reset, bit3 reserved
// - bits 4-7 address, 8-15 data
// - grant: transmit one cycle, then idle
// - link holds or transmits; hold drives data-on
// - link sends transmit with first bits
// - link ends: idle/hold, idle, release
// - hold after packet: wait, regrant
// - same speed for whole ownership
// - phy idles one clock after second idle
// - extra clock at each ownership change; here only at the link's release, none after grant
// - receive code with both lines high
// - speed code 00 then packet bits
// - idle ends receive
// - logic one asserts; totem only in packets
// - arbitration clock 49.152 MHz
// - receive code means request lost
//
// Purpose: shared codes, field positions and timing of the phy-link port
// Assumes: one 125 MHz clock shared by both ends
// Notes: register map belongs to the link end's apb slave
package plst_pkg;
  localparam logic [1:0] PHY_IDLE = 2'h0;
  localparam logic [1:0] PHY_STATUS = 2'h1;
  localparam logic [1:0] PHY_RECEIVE = 2'h2;
  localparam logic [1:0] PHY_TRANSMIT = 2'h3;
  localparam logic [1:0] LNK_IDLE = 2'h0;
  localparam logic [1:0] LNK_HOLD = 2'h1;
  localparam logic [1:0] LNK_TRANSMIT = 2'h2;
  localparam logic [1:0] DIBIT_HIGH = 2'h3;
  localparam logic [1:0] SPEED_CODE = 2'h0;
  // status stream layout
  localparam int STAT_ARB_GAP_BIT = 0;
  localparam int STAT_SUB_GAP_BIT = 1;
  localparam int STAT_BUS_RESET_BIT = 2;
  localparam int STAT_RSVD_BIT = 3;
  localparam int STAT_ADDR_LSB = 4;
  localparam int STAT_DATA_LSB = 8;
  localparam int STAT_WIDTH = 16;
  localparam int STAT_SHORT_BITS = 4;
  localparam logic [2:0] STAT_SHORT_LAST = 3'(STAT_SHORT_BITS / 2 - 1);
  localparam logic [2:0] STAT_FULL_LAST = 3'(STAT_WIDTH / 2 - 1);
  // arbitration clock from the system clock by fractional divider
  localparam int CLK_KHZ = 125000;
  localparam int ARB_CLK_KHZ = 49152;
  localparam logic [3:0] REGRANT_ARB_CLKS = 4'h8;
  // link apb register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0c;
  localparam logic [7:0] REG_RXINFO = 8'h10;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_HOLD_FIRST_BIT = 1;
  localparam int CTRL_BUSY_BIT = 2;
  localparam int CTRL_LOST_BIT = 3;
  localparam int CTRL_MORE_BIT = 4;
  localparam int STATUS_FULL_BIT = 16;
  localparam logic [31:0] TXDATA_RST = 32'h0;
endpackage

// File: plst_link_if.sv
// Purpose: phy-link two-bit control pair and two data lines
// Assumes: undriven lines read as zero
// Notes: each side drives only while its enable is low
`timescale 1ns/1ns
interface plst_link_if;
  logic [1:0] phyCtl;
  logic [1:0] phyData;
  logic phyOe_n;
  logic [1:0] lnkCtl;
  logic [1:0] lnkData;
  logic lnkOe_n;
  logic reqLine;
  logic [1:0] ctlWire;
  logic [1:0] dataWire;
  // line level from whichever side enables its drivers
  assign ctlWire = !phyOe_n ? phyCtl : (!lnkOe_n ? lnkCtl : 2'h0);
  assign dataWire = !phyOe_n ? phyData : (!lnkOe_n ? lnkData : 2'h0);
  modport phy (output phyCtl, output phyData, output phyOe_n, input ctlWire, input dataWire, input reqLine);
  modport lnk (output lnkCtl, output lnkData, output lnkOe_n, output reqLine, input ctlWire, input dataWire);
endinterface

// File: plst_link_end.sv
// Purpose: link end of the phy-link port with an apb register slave
// Assumes: one packet is one 32-bit word of sixteen dibits
// Notes: all decisions use registered copies of the lines
`timescale 1ns/1ns
module plst_link_end #(
  parameter int TX_DIBITS = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  plst_link_if.lnk phy,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // one apb word feeds one packet, so the count is fixed
  if (TX_DIBITS != 16) begin
    $error("transmit word holds exactly sixteen dibits");
  end

  typedef enum logic [2:0] {L_IDLE, L_HOLD, L_SEND, L_POST1, L_POST2} plst_lnk_state_t;

  plst_lnk_state_t state_reg;
  logic [1:0] ctlQ_reg;
  logic [1:0] dataQ_reg;
  logic [4:0] idx_reg;
  logic txPend_reg;
  logic holdFirst_reg;
  logic more_reg;
  logic lost_reg;
  logic [31:0] txWord_reg;
  logic [15:0] statShift_reg;
  logic [15:0] lastStat_reg;
  logic statFull_reg;
  logic [3:0] statCnt_reg;
  logic inRx_reg;
  logic spdSeen_reg;
  logic [31:0] rxShift_reg;
  logic [31:0] rxWord_reg;
  logic [5:0] rxCnt_reg;
  logic [5:0] rxLen_reg;
  logic wrEn;
  logic listening;

  assign wrEn = psel && penable && pready && pwrite;
  assign listening = (state_reg == L_IDLE) && phy.lnkOe_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctlQ_reg <= 2'h0;
      dataQ_reg <= 2'h0;
    end else begin
      ctlQ_reg <= phy.ctlWire;
      dataQ_reg <= phy.dataWire;
    end
  end

  // transmit sequencer; drive starts two cycles after the grant cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= L_IDLE;
      idx_reg <= 5'h0;
      phy.lnkOe_n <= 1'b1;
      phy.lnkCtl <= plst_pkg::LNK_IDLE;
      phy.lnkData <= 2'h0;
    end else begin
      case (state_reg)
        L_IDLE: begin
          phy.lnkOe_n <= 1'b1;
          if (listening && txPend_reg && ctlQ_reg == plst_pkg::PHY_TRANSMIT) begin
            phy.lnkOe_n <= 1'b0;
            if (holdFirst_reg) begin
              phy.lnkCtl <= plst_pkg::LNK_HOLD;
              state_reg <= L_HOLD;
            end else begin
              phy.lnkCtl <= plst_pkg::LNK_TRANSMIT;
              phy.lnkData <= txWord_reg[1:0];
              idx_reg <= 5'h1;
              state_reg <= L_SEND;
            end
          end
        end
        L_HOLD: begin
          phy.lnkCtl <= plst_pkg::LNK_TRANSMIT;
          phy.lnkData <= txWord_reg[1:0];
          idx_reg <= 5'h1;
          state_reg <= L_SEND;
        end
        L_SEND: begin
          if (idx_reg == 5'(TX_DIBITS)) begin
            phy.lnkCtl <= more_reg ? plst_pkg::LNK_HOLD : plst_pkg::LNK_IDLE;
            phy.lnkData <= 2'h0;
            state_reg <= L_POST1;
          end else begin
            phy.lnkData <= txWord_reg[{idx_reg[3:0], 1'b0} +: 2];
            idx_reg <= idx_reg + 5'h1;
          end
        end
        L_POST1: begin
          phy.lnkCtl <= plst_pkg::LNK_IDLE;
          state_reg <= L_POST2;
        end
        L_POST2: begin
          phy.lnkOe_n <= 1'b1;
          state_reg <= L_IDLE;
        end
        default: state_reg <= L_IDLE;
      endcase
    end
  end

  // request level, raised a clock after the interface is seen idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phy.reqLine <= 1'b0;
    end else begin
      phy.reqLine <= txPend_reg && listening && ctlQ_reg == plst_pkg::PHY_IDLE;
    end
  end

  // status and receive capture while the phy owns the lines
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      statShift_reg <= 16'h0;
      lastStat_reg <= 16'h0;
      statFull_reg <= 1'b0;
      statCnt_reg <= 4'h0;
      inRx_reg <= 1'b0;
      spdSeen_reg <= 1'b0;
      rxShift_reg <= 32'h0;
      rxWord_reg <= 32'h0;
      rxCnt_reg <= 6'h0;
      rxLen_reg <= 6'h0;
    end else if (listening) begin
      if (ctlQ_reg == plst_pkg::PHY_STATUS && statCnt_reg < 4'h8) begin
        statShift_reg[{statCnt_reg[2:0], 1'b0} +: 2] <= dataQ_reg;
        statCnt_reg <= statCnt_reg + 4'h1;
      end else if (ctlQ_reg != plst_pkg::PHY_STATUS && statCnt_reg != 4'h0) begin
        // partial streams cut by a packet are dropped
        if (statCnt_reg == 4'h2) begin
          lastStat_reg[3:0] <= statShift_reg[3:0];
          statFull_reg <= 1'b0;
        end else if (statCnt_reg == 4'h8) begin
          lastStat_reg <= statShift_reg;
          statFull_reg <= 1'b1;
        end
        statCnt_reg <= 4'h0;
      end
      if (ctlQ_reg == plst_pkg::PHY_RECEIVE) begin
        inRx_reg <= 1'b1;
        if (!spdSeen_reg) begin
          // speed is fixed for this bus, so the code is only a marker
          spdSeen_reg <= dataQ_reg != plst_pkg::DIBIT_HIGH;
        end else begin
          rxShift_reg <= {dataQ_reg, rxShift_reg[31:2]};
          rxCnt_reg <= rxCnt_reg + 6'h1;
        end
      end else if (inRx_reg) begin
        inRx_reg <= 1'b0;
        spdSeen_reg <= 1'b0;
        rxWord_reg <= rxShift_reg;
        rxLen_reg <= rxCnt_reg;
        rxCnt_reg <= 6'h0;
      end
    end
  end

  // software control; the lost flag keeps a set over a same-cycle clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txPend_reg <= 1'b0;
      holdFirst_reg <= 1'b0;
      more_reg <= 1'b0;
      lost_reg <= 1'b0;
      txWord_reg <= plst_pkg::TXDATA_RST;
    end else begin
      if (state_reg == L_POST2) begin
        txPend_reg <= more_reg;
        more_reg <= 1'b0;
      end else if (wrEn && paddr == plst_pkg::REG_CTRL) begin
        if (pwdata[plst_pkg::CTRL_GO_BIT]) begin
          txPend_reg <= 1'b1;
        end
        holdFirst_reg <= pwdata[plst_pkg::CTRL_HOLD_FIRST_BIT];
        more_reg <= pwdata[plst_pkg::CTRL_MORE_BIT];
      end
      if (listening && txPend_reg && ctlQ_reg == plst_pkg::PHY_RECEIVE) begin
        lost_reg <= 1'b1;
      end else if (wrEn && paddr == plst_pkg::REG_CTRL && pwdata[plst_pkg::CTRL_LOST_BIT]) begin
        lost_reg <= 1'b0;
      end
      if (wrEn && paddr == plst_pkg::REG_TXDATA && state_reg == L_IDLE) begin
        txWord_reg <= pwdata;
      end
    end
  end

  // read data latched in the setup cycle, ready in the access cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable) begin
        case (paddr)
          plst_pkg::REG_CTRL: prdata <= {27'h0, more_reg, lost_reg, txPend_reg, holdFirst_reg, 1'b0};
          plst_pkg::REG_TXDATA: prdata <= txWord_reg;
          plst_pkg::REG_STATUS: prdata <= {15'h0, statFull_reg, lastStat_reg};
          plst_pkg::REG_RXDATA: prdata <= rxWord_reg;
          plst_pkg::REG_RXINFO: prdata <= {26'h0, rxLen_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

// File: plst_port_props.sv
// Purpose: line checks between the phy and link ends
// Assumes: one clock, async active-low reset
// Notes: watches each side's drive, not only the wire
`timescale 1ns/1ns
module plst_port_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] phyCtl,
  input wire logic [1:0] phyData,
  input wire logic phyOe_n,
  input wire logic [1:0] lnkCtl,
  input wire logic lnkOe_n,
  input wire logic reqLine,
  input wire logic [1:0] ctlWire
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic st;
  logic rx;
  // phy owns the pair and shows status or receive
  assign st = !phyOe_n && phyCtl == 2'h1;
  assign rx = !phyOe_n && phyCtl == 2'h2;
  a_status_pair: assert property ($rose(st) |=> phyCtl == 2'h1 || rx)
    else $error("status dropped after one dibit");
  a_status_max: assert property (st [*8] |=> !st)
    else $error("status longer than sixteen bits");
  a_status_gap: assert property (st ##1 !st |-> !phyOe_n && phyCtl[0] == 1'h0)
    else $error("status not followed by idle or receive");
  a_grant_once: assert property (!phyOe_n && phyCtl == 2'h3 |=> !phyOe_n && phyCtl == 2'h0 ##1 phyOe_n)
    else $error("grant not one cycle then idle");
  a_link_takes: assert property (!phyOe_n && phyCtl == 2'h3 |-> ##2 !lnkOe_n && lnkCtl inside {2'h1, 2'h2})
    else $error("link did not hold or transmit after grant");
  a_link_tail: assert property (!lnkOe_n && lnkCtl == 2'h2 ##1 lnkCtl != 2'h2 |=> !lnkOe_n && lnkCtl == 2'h0 ##1 lnkOe_n)
    else $error("link packet tail wrong");
  a_phy_back: assert property ($rose(lnkOe_n) |-> ##[0:1] !phyOe_n && phyCtl == 2'h0)
    else $error("phy late taking the pair back");
  a_rx_lead: assert property ($rose(rx) |-> phyData == 2'h3 ##1 rx && phyData == 2'h0)
    else $error("receive lead-in wrong");
  a_rx_end: assert property (rx ##1 phyCtl != 2'h2 |-> !phyOe_n && phyCtl == 2'h0)
    else $error("receive not ended by idle");
  a_one_driver: assert property (phyOe_n || lnkOe_n)
    else $error("both ends drive the lines");
  a_req_drop: assert property (ctlWire == 2'h2 [*3] |-> !reqLine)
    else $error("request kept during receive");
  c_full: cover property (st [*8]);
  c_grant: cover property (!phyOe_n && phyCtl == 2'h3);
  c_rx: cover property ($rose(rx));
endmodule

// File: phy_link_status_tx_rx_port_bench.sv
// Purpose: drives both ends over apb and the phy side pins
// Assumes: apb answers in its access cycle
// Notes: line codes, packet outputs and arbTick sampled on the falling edge, apb and busRequest on the rising edge
`timescale 1ns/1ns
module phy_link_status_tx_rx_port_bench;
  typedef struct {logic [2:0] flags; logic [4:0] want;} plst_row_t;
  plst_row_t rows [4] = '{'{3'h1, 5'h01}, '{3'h2, 5'h02}, '{3'h4, 5'h04}, '{3'h7, 5'h07}};
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, regReadReq = 1'h0, arbWon = 1'h0;
  logic arbGapSeen = 1'h0, subGapSeen = 1'h0, busResetSeen = 1'h0;
  logic rxStart = 1'h0, rxValid = 1'h0, rxEnd = 1'h0;
  logic [1:0] rxDibit = 2'h0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regData = 8'h00, paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, got;
  logic pready, pslverr, err, busRequest, txValid, busDataOn, busTotem, seenOn, arbTick;
  logic [1:0] txDibit;
  int mismatches = 0;
  int checks_done = 0;
  plst_link_if linkBus ();
  plst_phy_end plst_phy_end_inst (.clock, .rst_n, .lnk(linkBus), .arbGapSeen, .subGapSeen, .busResetSeen,
    .regReadReq, .regAddr, .regData, .busRequest, .arbWon, .rxStart, .rxValid, .rxDibit, .rxEnd, .txValid,
    .txDibit, .busDataOn, .busTotem, .arbTick(arbTick));
  plst_link_end plst_link_end_inst (.clock, .rst_n, .phy(linkBus), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  plst_port_props plst_port_props_inst (.clock, .rst_n, .phyCtl(linkBus.phyCtl), .phyData(linkBus.phyData),
    .phyOe_n(linkBus.phyOe_n), .lnkCtl(linkBus.lnkCtl), .lnkOe_n(linkBus.lnkOe_n), .reqLine(linkBus.reqLine),
    .ctlWire(linkBus.ctlWire));
  // 125 MHz
  always #4 clock = ~clock;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one apb transfer; held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      check("apb wait", 32'h0, 32'h1);
      end_of_test();
    end
  endtask
  // bounded wait for the phy code to appear or go
  task automatic waitCtl(input logic [1:0] code, input logic want);
    int n;
    n = 0;
    while ((linkBus.phyCtl === code) != want && n < 400) begin
      @(negedge clock);
      n++;
    end
    if (n >= 400) begin
      check("line wait", 32'h0, 32'h1);
      end_of_test();
    end
  endtask
  initial begin
    int k;
    int n;
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    repeat (2) @(posedge clock);
    // flag pulses give a short status stream
    foreach (rows[i]) begin
      {busResetSeen, subGapSeen, arbGapSeen} <= rows[i].flags;
      @(posedge clock);
      {busResetSeen, subGapSeen, arbGapSeen} <= 3'h0;
      waitCtl(2'h1, 1'h1);
      waitCtl(2'h1, 1'h0);
      // the link files the stream only after its registered copy goes idle
      repeat (2) @(posedge clock);
      apb(1'h0, plst_pkg::REG_STATUS, 32'h0);
      check("short status", 32'({rd[16], rd[3:0]}), 32'(rows[i].want));
    end
    // register answer forces the full stream
    regAddr <= 4'ha;
    regData <= 8'h5c;
    regReadReq <= 1'h1;
    @(posedge clock);
    regReadReq <= 1'h0;
    waitCtl(2'h1, 1'h1);
    waitCtl(2'h1, 1'h0);
    repeat (2) @(posedge clock);
    apb(1'h0, plst_pkg::REG_STATUS, 32'h0);
    check("full status", 32'(rd[16:0]), 32'h15ca0);
    // receive beats a pending request and suspends a status
    apb(1'h1, plst_pkg::REG_TXDATA, 32'h1234abcd);
    apb(1'h1, plst_pkg::REG_CTRL, 32'h3);
    for (n = 0; busRequest !== 1'h1 && n < 50; n++) @(posedge clock);
    check("request", 32'(busRequest), 32'h1);
    arbGapSeen <= 1'h1;
    @(posedge clock);
    arbGapSeen <= 1'h0;
    // status starts, then the packet cuts it after one dibit
    @(posedge clock);
    rxStart <= 1'h1;
    @(posedge clock);
    rxStart <= 1'h0;
    @(posedge clock);
    for (k = 0; k < 16; k++) begin
      rxValid <= 1'h1;
      rxDibit <= 2'(32'hc3a50f96 >> (2 * k));
      @(posedge clock);
    end
    rxValid <= 1'h0;
    rxEnd <= 1'h1;
    @(posedge clock);
    rxEnd <= 1'h0;
    // the link files the word two edges after the line goes idle
    repeat (2) @(posedge clock);
    apb(1'h0, plst_pkg::REG_RXDATA, 32'h0);
    check("rx word", rd, 32'hc3a50f96);
    apb(1'h0, plst_pkg::REG_RXINFO, 32'h0);
    check("rx count", 32'(rd[5:0]), 32'h10);
    apb(1'h0, plst_pkg::REG_CTRL, 32'h0);
    check("lost busy", 32'(rd[3:2]), 32'h3);
    apb(1'h0, plst_pkg::REG_STATUS, 32'h0);
    check("resumed status", 32'(rd[0]), 32'h1);
    // clear lost, keep hold-first, ask for a second packet by hold
    apb(1'h1, plst_pkg::REG_CTRL, 32'h1a);
    for (n = 0; busRequest !== 1'h1 && n < 50; n++) @(posedge clock);
    check("request again", 32'(busRequest), 32'h1);
    arbWon <= 1'h1;
    @(posedge clock);
    arbWon <= 1'h0;
    seenOn = 1'h0;
    got = 32'h0;
    k = 0;
    for (n = 0; k < 32 && n < 400; n++) begin
      @(negedge clock);
      if (busDataOn === 1'h1) seenOn = 1'h1;
      if (txValid === 1'h1) begin
        got[2*(k%16)+:2] = txDibit;
        check("totem", 32'(busTotem), 32'h1);
        k++;
      end
    end
    check("packets", 32'(k), 32'h20);
    check("tx word", got, 32'h1234abcd);
    check("data on", 32'(seenOn), 32'h1);
    n = 0;
    do begin
      apb(1'h0, plst_pkg::REG_CTRL, 32'h0);
      n++;
    end while (rd[2] !== 1'h0 && n < 30);
    check("busy clear", 32'(rd[2]), 32'h0);
    // unmapped place is refused
    apb(1'h0, 8'h40, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    // 15625 clocks of 8 ns hold exactly 6144 arbitration periods
    k = 0;
    repeat (15625) begin
      @(negedge clock);
      if (arbTick === 1'h1) k++;
    end
    check("arb ticks", 32'(k), 32'h1800);
    // mid-run reset: phy drives idle, registers cleared
    rst_n <= 1'h0;
    @(negedge clock);
    check("reset lines", 32'({linkBus.phyOe_n, linkBus.lnkOe_n, linkBus.phyCtl}), 32'h4);
    @(posedge clock);
    rst_n <= 1'h1;
    repeat (2) @(posedge clock);
    apb(1'h0, plst_pkg::REG_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    end_of_test();
  end
endmodule
